// ### rtl/axis_io_pkg.sv
// Shared constants and types for the axis feedback and safety block.
// Assumes a 10 MHz core clock and a 16-bit register port.
package axis_io_pkg;

	localparam int DATA_W = 16;
	localparam int POS_W  = 32;

	// Register port offsets, write side.
	localparam logic [3:0] ADDR_CMD    = 4'h0;
	localparam logic [3:0] ADDR_DATA   = 4'h1;
	localparam logic [3:0] ADDR_MODE2  = 4'h2;
	localparam logic [3:0] ADDR_MODE3  = 4'h3;
	// Register port offsets, read side.
	localparam logic [3:0] ADDR_MAIN   = 4'h0;
	localparam logic [3:0] ADDR_ERR    = 4'h2;
	localparam logic [3:0] ADDR_LVL    = 4'h3;
	localparam logic [3:0] ADDR_POS_LO = 4'h4;
	localparam logic [3:0] ADDR_POS_HI = 4'h5;

	// Command codes written into the command register.
	localparam logic [15:0] CMD_HALT     = 16'h0057;
	localparam logic [15:0] CMD_RESET    = 16'h00ff;
	localparam logic [15:0] CMD_DCC_OUT  = 16'h0072;
	localparam logic [15:0] CMD_DCC_CFG  = 16'h0024;
	localparam logic [15:0] CMD_GP_CFG   = 16'h0021;

	// Field positions of mode_reg_three.
	localparam int FB_SEL_LO = 8;
	localparam int FB_SEL_HI = 9;
	localparam int FB_POL    = 10;
	localparam int FB_SWAP   = 11;
	localparam int END_SWAP  = 12;
	// Field positions of mode_reg_two.
	localparam int SET_EN    = 6;
	localparam int SET_HI    = 7;
	localparam int ALM_EN    = 8;
	localparam int ALM_HI    = 9;
	localparam int END_EN    = 10;
	localparam int END_HI    = 11;
	localparam int END_DECEL = 12;
	// Field positions of error_status_reg.
	localparam int ERR_ALM_LO = 4;
	localparam int ERR_EMG_LO = 5;
	localparam int ERR_ALM_HI = 14;
	localparam int ERR_EMG_HI = 15;
	// Field positions of main_status_reg, also used for the pins.
	localparam int MS_DRIVE  = 0;
	localparam int MS_ACCEL  = 2;
	localparam int MS_CRUISE = 3;
	localparam int MS_DECEL  = 4;
	localparam int MS_JUP    = 5;
	localparam int MS_FLAT   = 6;
	localparam int MS_JDN    = 7;
	// Data fields of the set-up commands.
	localparam int GP_SEL_BIT  = 0;
	localparam int DCC_LVL_BIT = 3;
	localparam int DCC_W_LO    = 4;
	localparam int DCC_W_HI    = 6;

	// Bit index of each pin in the synchroniser vectors.
	localparam int IN_EA  = 0;
	localparam int IN_EB  = 1;
	localparam int IN_LP  = 2;
	localparam int IN_LM  = 3;
	localparam int IN_SET = 4;
	localparam int IN_ALM = 5;
	localparam int IN_EMG = 6;
	localparam int IN_N   = 7;

	// Reset must be seen low on more than 8 edges.
	localparam int RST_SAMPLES = 9;

	// Timing: clear pulse width is a unit times two to the code.
	localparam int CLK_HZ       = 10_000_000;
	localparam int DCC_UNIT_US  = 10;
	localparam int DCC_UNIT_CYC = DCC_UNIT_US * (CLK_HZ / 1_000_000);
	localparam int DCC_CNT_W    = 14;

	// Reset level of the synchronisers: emergency input idles high.
	localparam logic [IN_N-1:0] SYNC_RST = 7'h40;

	typedef enum logic [1:0] {
		FB_QUAD4 = 2'b00,
		FB_QUAD2 = 2'b01,
		FB_QUAD1 = 2'b10,
		FB_UPDN  = 2'b11
	} fb_mode_e;

	typedef enum logic [1:0] {
		DRV_STOP   = 2'b00,
		DRV_RUN    = 2'b01,
		DRV_SETTLE = 2'b10
	} drv_e;

	typedef enum logic {
		DCC_IDLE  = 1'b0,
		DCC_PULSE = 1'b1
	} dcc_e;

	// Pins from encoder, end stops and servo driver, index order above.
	typedef struct packed {
		logic emergency_halt_n;
		logic alarm_input;
		logic servo_settled_input;
		logic minus_end_stop_input;
		logic plus_end_stop_input;
		logic encoder_b_or_down_input;
		logic encoder_a_or_up_input;
	} axis_pins_s;

	// Drive phase reported by the pulse generator.
	typedef struct packed {
		logic active;
		logic accel;
		logic cruise;
		logic decel;
		logic jerk_up;
		logic flat_accel;
		logic jerk_down;
	} phase_s;

	// Stop requests to the pulse generator.
	typedef struct packed {
		logic halt;
		logic plus_inhibit;
		logic minus_inhibit;
		logic end_decel;
	} stop_req_s;

	typedef struct packed {
		logic [RST_SAMPLES-1:0] rst_hist;
		logic [IN_N-1:0]        s1;
		logic [IN_N-1:0]        s2;
		logic [IN_N-1:0]        s3;
		logic [IN_N-1:0]        filt;
		logic [DATA_W-1:0]      mode2;
		logic [DATA_W-1:0]      mode3;
		logic [DATA_W-1:0]      cmd_data;
		logic                   gp_sel;
		logic [3:0]             dcc_cfg;
		dcc_e                   dcc_st;
		logic [DCC_CNT_W-1:0]   dcc_cnt;
		logic                   dcc_pin;
		drv_e                   drv_st;
		logic [POS_W-1:0]       pos;
		logic                   err_alm;
		logic                   err_emg;
		stop_req_s              stop;
		logic [7:0]             gp_pins;
		logic [DATA_W-1:0]      rdata;
	} state_s;

endpackage

// ### rtl/axis_feedback_and_safety_io.sv
// Encoder decoding, end stop and servo driver handling, emergency stop,
// deviation counter clear pulse and drive status pins for one axis.
// Assumes a pulse generator beside it that reports its drive phase and
// obeys the stop requests, and a host on the plain register port.
`timescale 1ns/100ps

module axis_feedback_and_safety_io
	import axis_io_pkg::*;
(
	input  wire logic        core_clk_i,   // System clock, 10 MHz.
	input  wire logic        rst_n_i,      // Synchronous reset, low.
	input  wire logic [3:0]  addr_i,       // Register offset.
	input  wire logic [15:0] wdata_i,      // Write data.
	input  wire logic        wr_i,         // Write strobe.
	input  wire logic        rd_i,         // Read strobe.
	output logic      [15:0] rdata_o,      // Read data, next cycle.
	input  wire axis_pins_s  pins_i,       // Asynchronous axis pins.
	input  wire phase_s      phase_i,      // Generator drive phase.
	output stop_req_s        stop_o,       // Stop requests.
	output logic             error_counter_clear_out, // Clear pin.
	output logic      [7:0]  gp_pin_o      // Status pins.
);

	state_s st_r;
	state_s st_nxt;

	// Combinational helpers, each given a value in the process before its first use.
	logic [IN_N-1:0]   filt_n;
	logic [1:0]        ab_c;
	logic [1:0]        ab_p;
	logic              ea_e;
	logic              eb_e;
	logic              cnt_en;
	logic              cnt_up;
	fb_mode_e          fb_mode;
	logic              lp;
	logic              lm;
	logic              end_hit_p;
	logic              end_hit_m;
	logic              settled;
	logic              alarm_act;
	logic              emg_act;
	logic              cmd_wr;
	logic              halt_cmd;
	logic              reset_cmd;
	logic              drive_now;
	logic [7:0]        phase_vec;
	logic [DATA_W-1:0] main_stat;
	logic [DATA_W-1:0] err_stat;
	logic [DATA_W-1:0] lvl_stat;
	logic [DCC_CNT_W-1:0] dcc_len;

	// An input is active when its level matches the configured level.
	function automatic logic is_active(input logic lvl, input logic hi);
		return lvl == hi;
	endfunction

	// Encoder pair after polarity and swap, returned as {a, b}.
	function automatic logic [1:0] enc_pair(input logic [IN_N-1:0] v,
			input logic pol, input logic swap);
		logic a;
		logic b;
		a = v[IN_EA] ^ pol;
		b = v[IN_EB] ^ pol;
		return swap ? {b, a} : {a, b};
	endfunction

	// Status outputs follow directly from registered state.
	assign rdata_o                 = st_r.rdata;
	assign stop_o                  = st_r.stop;
	assign error_counter_clear_out = st_r.dcc_pin;
	assign gp_pin_o                = st_r.gp_pins;

	// Next-state logic for the whole block.
	always_comb begin
		st_nxt = st_r;

		// Three-stage synchroniser; a change is taken once stages two and
		// three agree, which also rejects a single-cycle glitch.
		st_nxt.s1 = pins_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		filt_n = st_r.filt ^ ((st_r.filt ^ st_r.s3) & ~(st_r.s2 ^ st_r.s3));
		st_nxt.filt = filt_n;

		// Encoder decoding compares new and previous filtered levels.
		ab_c = enc_pair(filt_n, st_r.mode3[FB_POL],
			st_r.mode3[FB_SWAP]);
		ab_p = enc_pair(st_r.filt, st_r.mode3[FB_POL],
			st_r.mode3[FB_SWAP]);
		ea_e = ab_c[1] ^ ab_p[1];
		eb_e = ab_c[0] ^ ab_p[0];
		fb_mode = fb_mode_e'(st_r.mode3[FB_SEL_HI:FB_SEL_LO]);
		cnt_en = 1'b0;
		cnt_up = 1'b0;
		case (fb_mode)
			FB_QUAD4: begin
				// Both phases moving at once is a lost step; skip it.
				cnt_en = ea_e ^ eb_e;
				cnt_up = ab_c[1] ^ ab_p[0];
			end
			FB_QUAD2: begin
				cnt_en = ea_e & ~eb_e;
				cnt_up = ab_c[1] ^ ab_c[0];
			end
			FB_QUAD1: begin
				cnt_en = ab_c[1] & ~ab_p[1] & ~eb_e;
				cnt_up = ~ab_c[0];
			end
			FB_UPDN: begin
				// Pulses on both inputs in one cycle cancel out.
				cnt_en = (ab_c[1] & ~ab_p[1]) ^ (ab_c[0] & ~ab_p[0]);
				cnt_up = ab_c[1] & ~ab_p[1];
			end
			default: begin
				cnt_en = 1'b0;
				cnt_up = 1'b0;
			end
		endcase
		if (cnt_en) begin
			st_nxt.pos = cnt_up ? st_r.pos + 32'h1 : st_r.pos - 32'h1;
		end

		// End stops, optionally swapped, then qualified by level and enable.
		lp = st_r.mode3[END_SWAP] ? st_r.filt[IN_LM] : st_r.filt[IN_LP];
		lm = st_r.mode3[END_SWAP] ? st_r.filt[IN_LP] : st_r.filt[IN_LM];
		end_hit_p = st_r.mode2[END_EN] &
			is_active(lp, st_r.mode2[END_HI]);
		end_hit_m = st_r.mode2[END_EN] &
			is_active(lm, st_r.mode2[END_HI]);
		st_nxt.stop.plus_inhibit  = end_hit_p;
		st_nxt.stop.minus_inhibit = end_hit_m;
		st_nxt.stop.end_decel     = st_r.mode2[END_DECEL];

		// Servo driver inputs and the fixed-polarity emergency input.
		settled = st_r.mode2[SET_EN] &
			is_active(st_r.filt[IN_SET], st_r.mode2[SET_HI]);
		alarm_act = st_r.mode2[ALM_EN] &
			is_active(st_r.filt[IN_ALM], st_r.mode2[ALM_HI]);
		emg_act = ~st_r.filt[IN_EMG];

		// Command decode.
		cmd_wr    = wr_i & (addr_i == ADDR_CMD);
		halt_cmd  = cmd_wr & (wdata_i == CMD_HALT);
		reset_cmd = cmd_wr & (wdata_i == CMD_RESET);

		// The halt request is held while any cause lasts.
		st_nxt.stop.halt = halt_cmd | reset_cmd | emg_act |
			(alarm_act & phase_i.active);

		// Error flags: a new cause wins over a command reset clearing it.
		st_nxt.err_alm = (st_r.err_alm & ~reset_cmd) |
			(alarm_act & phase_i.active);
		st_nxt.err_emg = (st_r.err_emg & ~reset_cmd) | emg_act;

		// Drive tracking: after pulses end, wait for the servo to settle.
		case (st_r.drv_st)
			DRV_STOP: begin
				if (phase_i.active) begin
					st_nxt.drv_st = DRV_RUN;
				end
			end
			DRV_RUN: begin
				if (!phase_i.active) begin
					if (st_r.mode2[SET_EN] && !settled && !reset_cmd) begin
						st_nxt.drv_st = DRV_SETTLE;
					end else begin
						st_nxt.drv_st = DRV_STOP;
					end
				end
			end
			DRV_SETTLE: begin
				if (phase_i.active) begin
					st_nxt.drv_st = DRV_RUN;
				end else if (!st_r.mode2[SET_EN] || settled || reset_cmd) begin
					st_nxt.drv_st = DRV_STOP;
				end
			end
			default: begin
				st_nxt.drv_st = DRV_STOP;
			end
		endcase

		// Drive phase bits, all zero when stopped.
		drive_now = phase_i.active | (st_r.drv_st == DRV_SETTLE);
		phase_vec = 8'h00;
		phase_vec[MS_DRIVE]  = drive_now;
		phase_vec[MS_ACCEL]  = phase_i.active & phase_i.accel;
		phase_vec[MS_CRUISE] = phase_i.active & phase_i.cruise;
		phase_vec[MS_DECEL]  = phase_i.active & phase_i.decel;
		phase_vec[MS_JUP]    = phase_i.active & phase_i.jerk_up;
		phase_vec[MS_FLAT]   = phase_i.active & phase_i.flat_accel;
		phase_vec[MS_JDN]    = phase_i.active & phase_i.jerk_down;
		main_stat = {8'h00, phase_vec};
		// Other pin functions live elsewhere, so unselected pins stay low.
		st_nxt.gp_pins = st_r.gp_sel ? phase_vec : 8'h00;

		// Register writes; set-up commands take the staged data word.
		if (wr_i && addr_i == ADDR_DATA) begin
			st_nxt.cmd_data = wdata_i;
		end
		if (wr_i && addr_i == ADDR_MODE2) begin
			st_nxt.mode2 = wdata_i;
		end
		if (wr_i && addr_i == ADDR_MODE3) begin
			st_nxt.mode3 = wdata_i;
		end
		if (cmd_wr && wdata_i == CMD_GP_CFG) begin
			st_nxt.gp_sel = st_r.cmd_data[GP_SEL_BIT];
		end
		if (cmd_wr && wdata_i == CMD_DCC_CFG) begin
			st_nxt.dcc_cfg = {st_r.cmd_data[DCC_W_HI:DCC_W_LO],
				st_r.cmd_data[DCC_LVL_BIT]};
		end

		// Clear pulse: width is the unit times two to the width code.
		dcc_len = DCC_CNT_W'(DCC_UNIT_CYC << st_r.dcc_cfg[3:1]);
		case (st_r.dcc_st)
			DCC_IDLE: begin
				st_nxt.dcc_pin = ~st_r.dcc_cfg[0];
			end
			DCC_PULSE: begin
				st_nxt.dcc_pin = st_r.dcc_cfg[0];
				if (st_r.dcc_cnt == '0) begin
					st_nxt.dcc_st  = DCC_IDLE;
					st_nxt.dcc_pin = ~st_r.dcc_cfg[0];
				end else begin
					st_nxt.dcc_cnt = st_r.dcc_cnt - 1'b1;
				end
			end
			default: begin
				st_nxt.dcc_st = DCC_IDLE;
			end
		endcase
		// A repeat command restarts the pulse; a command reset cuts it.
		if (cmd_wr && wdata_i == CMD_DCC_OUT) begin
			st_nxt.dcc_st  = DCC_PULSE;
			st_nxt.dcc_pin = st_r.dcc_cfg[0];
			st_nxt.dcc_cnt = dcc_len - 1'b1;
		end else if (reset_cmd) begin
			st_nxt.dcc_st  = DCC_IDLE;
			st_nxt.dcc_pin = ~st_r.dcc_cfg[0];
		end

		// Read side; data stand for one cycle only.
		err_stat = '0;
		err_stat[ERR_ALM_LO] = st_r.err_alm;
		err_stat[ERR_ALM_HI] = st_r.err_alm;
		err_stat[ERR_EMG_LO] = st_r.err_emg;
		err_stat[ERR_EMG_HI] = st_r.err_emg;
		// Raw pin levels, before swap or polarity, independent of drive.
		lvl_stat = {{(DATA_W-5){1'b0}}, st_r.filt[IN_EMG],
			st_r.filt[IN_ALM], st_r.filt[IN_SET],
			st_r.filt[IN_LM], st_r.filt[IN_LP]};
		st_nxt.rdata = '0;
		if (rd_i) begin
			case (addr_i)
				ADDR_MAIN:   st_nxt.rdata = main_stat;
				ADDR_ERR:    st_nxt.rdata = err_stat;
				ADDR_LVL:    st_nxt.rdata = lvl_stat;
				ADDR_POS_LO: st_nxt.rdata = st_r.pos[15:0];
				ADDR_POS_HI: st_nxt.rdata = st_r.pos[31:16];
				default:     st_nxt.rdata = '0;
			endcase
		end

		// Reset takes effect only after more than eight low samples; the
		// history shifts in on every edge, so it settles even from power-up.
		st_nxt.rst_hist = {st_r.rst_hist[RST_SAMPLES-2:0], ~rst_n_i};
		if (&st_nxt.rst_hist) begin
			st_nxt = '{rst_hist: st_nxt.rst_hist, s1: SYNC_RST, s2: SYNC_RST,
				s3: SYNC_RST, filt: SYNC_RST, dcc_pin: 1'b1,
				dcc_st: DCC_IDLE, drv_st: DRV_STOP, default: '0};
		end
	end

	// Single state register for the block.
	always_ff @(posedge core_clk_i) begin
		st_r <= st_nxt;
	end

	// Helper views for the checks below.
	logic in_rst;
	assign in_rst = &st_r.rst_hist;

	sequence a_rise_b_low;
		$rose(st_r.filt[IN_EA]) && !st_r.filt[IN_EB] &&
			$stable(st_r.filt[IN_EB]) && $stable(st_r.mode3);
	endsequence

	sequence dcc_request;
		wr_i && addr_i == ADDR_CMD && wdata_i == CMD_DCC_OUT &&
			st_r.dcc_cfg[3:1] == 3'h0;
	endsequence

	quad_count_up_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		(a_rise_b_low and (st_r.mode3[FB_SWAP:FB_SEL_LO] == 4'h0))
		|-> st_r.pos == $past(st_r.pos) + 32'h1)
		else $error("A leading B did not count up");

	quad_swap_down_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		(a_rise_b_low and (st_r.mode3[FB_SWAP:FB_SEL_LO] == 4'h8))
		|-> st_r.pos == $past(st_r.pos) - 32'h1)
		else $error("swapped encoder did not count down");

	two_edge_ign_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		$stable(st_r.mode3) && !st_r.mode3[FB_SWAP] &&
		st_r.mode3[FB_SEL_HI:FB_SEL_LO] == 2'b01 &&
		$changed(st_r.filt[IN_EB]) && $stable(st_r.filt[IN_EA])
		|-> $stable(st_r.pos))
		else $error("two-edge mode counted a B edge");

	one_edge_fall_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		$stable(st_r.mode3) && st_r.mode3[FB_SWAP:FB_SEL_LO] == 4'h2 &&
		$fell(st_r.filt[IN_EA]) |-> $stable(st_r.pos))
		else $error("single-edge mode counted a falling edge");

	emerg_halt_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		!st_r.filt[IN_EMG] |=> st_r.stop.halt && st_r.err_emg)
		else $error("emergency input did not halt and flag");

	halt_cmd_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		wr_i && addr_i == ADDR_CMD && wdata_i == CMD_HALT |=> st_r.stop.halt)
		else $error("instant stop command did not halt");

	alarm_halt_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		alarm_act && phase_i.active |=> st_r.stop.halt && st_r.err_alm)
		else $error("driver alarm did not halt and flag");

	dcc_pulse_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		dcc_request ##1 $stable(st_r.dcc_cfg)
		|-> (st_r.dcc_pin == st_r.dcc_cfg[0]) [*8])
		else $error("clear pulse not at configured level");

	settle_hold_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		st_r.drv_st != DRV_STOP && st_r.mode2[SET_EN] && !settled &&
		!reset_cmd && !phase_i.active |=> main_stat[MS_DRIVE])
		else $error("drive bit dropped before servo settled");

	end_stop_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		end_hit_p |=> st_r.stop.plus_inhibit)
		else $error("plus end stop did not inhibit");

	gp_mirror_a: assert property (@(posedge core_clk_i)
		disable iff (in_rst)
		st_r.gp_sel |=> gp_pin_o[MS_DRIVE] == $past(drive_now))
		else $error("drive pin does not mirror drive state");

endmodule

// ### tb/axis_far_side.sv
// Model of the far side: encoder, end stop sensors and servo driver.
// Assumes the bench gives one-cycle step requests on the core clock.
`timescale 1ns/100ps

module axis_far_side
	import axis_io_pkg::*;
(
	input  wire logic core_clk_i, // Core clock.
	input  wire logic fwd_i,      // One forward step.
	input  wire logic rev_i,      // One reverse step.
	input  wire logic updn_i,     // Pulse lines instead of quadrature.
	input  wire logic pol_i,      // Encoder lines active low.
	input  wire logic lim_p_i,    // Plus sensor level.
	input  wire logic lim_m_i,    // Minus sensor level.
	input  wire logic settled_i,  // Servo settled level.
	input  wire logic alarm_i,    // Servo alarm level.
	input  wire logic estop_n_i,  // Emergency button, low pressed.
	output axis_pins_s pins_o     // Pins toward the block.
);
	logic [1:0] q_r = 2'h0;
	logic [2:0] up_r = 3'h0;
	logic [2:0] dn_r = 3'h0;

	// Pulses last four cycles so the block's filter never drops them.
	always_ff @(posedge core_clk_i) begin
		q_r  <= q_r + {rev_i, fwd_i | rev_i};
		up_r <= fwd_i ? 3'h4 : up_r - {2'h0, up_r != 3'h0};
		dn_r <= rev_i ? 3'h4 : dn_r - {2'h0, dn_r != 3'h0};
	end

	// Forward stepping makes A lead B by a quarter cycle.
	always_comb begin
		pins_o.encoder_a_or_up_input   = pol_i ^ (updn_i ? up_r != 3'h0
			: q_r[0] ^ q_r[1]);
		pins_o.encoder_b_or_down_input = pol_i ^ (updn_i ? dn_r != 3'h0
			: q_r[1]);
		pins_o.plus_end_stop_input  = lim_p_i;
		pins_o.minus_end_stop_input = lim_m_i;
		pins_o.servo_settled_input  = settled_i;
		pins_o.alarm_input          = alarm_i;
		pins_o.emergency_halt_n     = estop_n_i;
	end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the axis feedback and safety block.
// Assumes the far side model drives the pins and the bench the phase.
`timescale 1ns/100ps

module tb_top;
	import axis_io_pkg::*;
	logic        core_clk_i, rst_n_i, wr_i, rd_i, dcc;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [7:0]  gp_pin_o;
	phase_s      phase_i;
	stop_req_s   stop_o;
	axis_pins_s  pins;
	logic        fwd, rev, pol, lim_p, lim_m, settled, alarm, estop_n;
	logic        updn;
	int          n_errors = 0;
	int          n_tests = 0;

	axis_feedback_and_safety_io dut (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins),
		.phase_i(phase_i), .stop_o(stop_o),
		.error_counter_clear_out(dcc), .gp_pin_o(gp_pin_o));

	axis_far_side far (.core_clk_i(core_clk_i), .fwd_i(fwd), .rev_i(rev),
		.updn_i(updn), .pol_i(pol), .lim_p_i(lim_p), .lim_m_i(lim_m),
		.settled_i(settled), .alarm_i(alarm), .estop_n_i(estop_n),
		.pins_o(pins));

	// A 100 ns clock.
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	task automatic give_verdict;
		$display("%0d checks, %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= v;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rchk(input logic [3:0] a, input logic [15:0] e,
		input string nm);
		@(posedge core_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(nm, rdata_o, e);
	endtask

	// Steps are spaced wide enough for the three-flop input filter.
	task automatic step(input logic up);
		@(posedge core_clk_i);
		fwd <= up;
		rev <= !up;
		@(posedge core_clk_i);
		fwd <= 1'b0;
		rev <= 1'b0;
		repeat (6) @(posedge core_clk_i);
	endtask

	task automatic t_enc;
		logic [15:0] e;
		int          gain[4];
		gain = '{4, 2, 1, 4};
		e = 16'h0000;
		for (int m = 0; m < 4; m++) begin
			// The far side sends pulse lines only in the up/down mode.
			updn <= (m == 3);
			wr(ADDR_MODE3, 16'(m) << 8);
			repeat (4) step(1'b1);
			e += 16'(gain[m]);
			rchk(ADDR_POS_LO, e, "pos mode");
		end
		step(1'b0);
		rchk(ADDR_POS_LO, e - 16'h0001, "pos down");
		wr(ADDR_MODE3, 16'h0200);
		updn <= 1'b0;
		repeat (4) step(1'b0);
		rchk(ADDR_POS_LO, e - 16'h0002, "pos rev");
		wr(ADDR_MODE3, 16'h0800);
		repeat (4) step(1'b1);
		rchk(ADDR_POS_LO, e - 16'h0006, "pos swap");
		pol  <= 1'b1;
		updn <= 1'b1;
		wr(ADDR_MODE3, 16'h0700);
		repeat (6) @(posedge core_clk_i);
		repeat (2) step(1'b1);
		rchk(ADDR_POS_LO, e - 16'h0004, "pos pol");
		pol  <= 1'b0;
		updn <= 1'b0;
		wr(ADDR_MODE3, 16'h0000);
		$display("encoder test done");
	endtask

	task automatic t_end;
		wr(ADDR_MODE2, 16'h1c00);
		lim_p <= 1'b1;
		repeat (6) @(negedge core_clk_i);
		chk("inhibit", {12'h000, stop_o}, 16'h0005);
		rchk(ADDR_LVL, 16'h0011, "levels");
		wr(ADDR_MODE3, 16'h1000);
		repeat (4) @(negedge core_clk_i);
		chk("swapped", {12'h000, stop_o}, 16'h0003);
		lim_p <= 1'b0;
		wr(ADDR_MODE3, 16'h0000);
		$display("end stop test done");
	endtask

	task automatic t_servo;
		wr(ADDR_MODE2, 16'h00c0);
		phase_i <= 7'b1100100;
		rchk(ADDR_MAIN, 16'h0025, "main accel");
		chk("pins off", {8'h00, gp_pin_o}, 16'h0000);
		wr(ADDR_DATA, 16'h0001);
		wr(ADDR_CMD, CMD_GP_CFG);
		repeat (3) @(negedge core_clk_i);
		chk("pins on", {8'h00, gp_pin_o}, 16'h0025);
		phase_i <= 7'b1001001;
		rchk(ADDR_MAIN, 16'h0091, "main jerk");
		chk("pins jerk", {8'h00, gp_pin_o}, 16'h0091);
		phase_i <= 7'b0000000;
		repeat (3) @(posedge core_clk_i);
		rchk(ADDR_MAIN, 16'h0001, "drive held");
		settled <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		rchk(ADDR_MAIN, 16'h0000, "drive done");
		chk("pins stop", {8'h00, gp_pin_o}, 16'h0000);
		settled <= 1'b0;
		$display("servo test done");
	endtask

	task automatic t_fault;
		logic seen;
		wr(ADDR_MODE2, 16'h0300);
		phase_i <= 7'b1010000;
		alarm   <= 1'b1;
		repeat (6) @(negedge core_clk_i);
		chk("alarm halt", {15'h0000, stop_o.halt}, 16'h0001);
		rchk(ADDR_ERR, 16'h4010, "alarm flags");
		rchk(ADDR_LVL, 16'h0018, "alarm level");
		alarm   <= 1'b0;
		phase_i <= 7'b0000000;
		wr(ADDR_CMD, CMD_RESET);
		rchk(ADDR_ERR, 16'h0000, "flags reset");
		estop_n <= 1'b0;
		repeat (6) @(negedge core_clk_i);
		chk("emg halt", {15'h0000, stop_o.halt}, 16'h0001);
		rchk(ADDR_ERR, 16'h8020, "emg flags");
		estop_n <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		wr(ADDR_CMD, CMD_RESET);
		repeat (3) @(negedge core_clk_i);
		chk("halt off", {15'h0000, stop_o.halt}, 16'h0000);
		wr(ADDR_CMD, CMD_HALT);
		seen = 1'b0;
		repeat (3) begin
			@(negedge core_clk_i);
			if (stop_o.halt === 1'b1)
				seen = 1'b1;
		end
		chk("halt cmd", {15'h0000, seen}, 16'h0001);
		$display("fault test done");
	endtask

	task automatic t_clear;
		int hi;
		hi = 0;
		wr(ADDR_DATA, 16'h0008);
		wr(ADDR_CMD, CMD_DCC_CFG);
		// The pin moves to the new idle level one cycle after the set-up.
		repeat (2) @(negedge core_clk_i);
		chk("clear idle", {15'h0000, dcc}, 16'h0000);
		wr(ADDR_CMD, CMD_DCC_OUT);
		repeat (200) begin
			@(negedge core_clk_i);
			if (dcc === 1'b1)
				hi++;
		end
		chk("clear width", 16'(hi), 16'h0064);
		$display("clear test done");
	endtask

	// A short low must leave state alone; a long one restores idle levels.
	task automatic t_reset;
		rst_n_i <= 1'b0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(negedge core_clk_i);
		chk("short reset", {15'h0000, dcc}, 16'h0000);
		rst_n_i <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(negedge core_clk_i);
		chk("long reset", {15'h0000, dcc}, 16'h0001);
		$display("reset test done");
	endtask

	// The block needs more than eight low edges to reset.
	initial begin
		{rst_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
		{fwd, rev, pol, updn, lim_p, lim_m, settled, alarm} = '0;
		phase_i = '0;
		estop_n = 1'b1;
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(negedge core_clk_i);
		chk("reset clear", {15'h0000, dcc}, 16'h0001);
		chk("reset pins", {8'h00, gp_pin_o}, 16'h0000);
		rchk(4'hf, 16'h0000, "unmapped");
		t_enc;
		t_end;
		t_servo;
		t_fault;
		t_clear;
		t_reset;
		give_verdict;
	end

	// Whole run is several hundred cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_errors++;
		give_verdict;
	end
endmodule
